/* core/cmd_fetch.sv */
// Co-processor side fetch engine that owns the command fetch pointer
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"
module cmd_fetch
  import cmd_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Pointer control
  input  wire logic [11:0] end_ptr,
  input  wire ptr_load_s   load,
  input  wire logic        fault,
  output      logic [11:0] ptr_q,
  output      logic        drained_q,
  // Ring read port
  output      logic [9:0]  rd_addr,
  input  wire logic [31:0] rd_data,
  // Command stream to the engine
  output      logic        cmd_valid_q,
  output      logic [31:0] cmd_data_q,
  input  wire logic        cmd_ready
);

  fetch_state_e state_q;
  logic         halted;
  logic         pending;

  // Fault value is not word aligned, so fetching stops until software reloads
  assign halted  = (ptr_q == `PTR_ERROR);
  assign pending = (ptr_q != end_ptr) && !halted;   // [R15]
  assign rd_addr = ptr_q[11:2];                     // [R07]

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= FETCH_IDLE;
    end else if (fault || load.en) begin
      state_q <= FETCH_IDLE;
    end else begin
      case (state_q)
        FETCH_IDLE: if (pending) state_q <= FETCH_READ;
        FETCH_READ: state_q <= FETCH_HOLD;
        FETCH_HOLD: if (cmd_ready) state_q <= FETCH_IDLE;
        default:    state_q <= FETCH_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Fetch pointer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_q <= `PTR_RESET;                          // [R04]
    end else if (fault) begin
      ptr_q <= `PTR_ERROR;                          // [R02]
    end else if (load.en) begin
      ptr_q <= load.value;                          // [R03]
    end else if (state_q == FETCH_HOLD && cmd_ready) begin
      ptr_q <= ring_next(ptr_q);                    // [R01] [R15]
    end
  end

  // One-cycle pulse when the last pending command has been taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drained_q <= 1'b0;
    end else begin
      drained_q <= !fault && !load.en && state_q == FETCH_HOLD && cmd_ready
                   && ring_next(ptr_q) == end_ptr;  // [R15]
    end
  end

  // --------------------------------------------------------------------------
  // Command output
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_valid_q <= 1'b0;
      cmd_data_q  <= 32'h0000_0000;
    end else if (fault || load.en) begin
      cmd_valid_q <= 1'b0;
    end else if (state_q == FETCH_READ) begin
      cmd_valid_q <= 1'b1;
      cmd_data_q  <= rd_data;
    end else if (state_q == FETCH_HOLD && cmd_ready) begin
      cmd_valid_q <= 1'b0;
    end
  end

endmodule : cmd_fetch

/* core/cmd_fifo_defs.svh */
// Offsets, field positions, reset values and geometry of the command ring
`ifndef CMD_FIFO_DEFS_SVH
`define CMD_FIFO_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_FETCH_PTR    16'h00f8
`define OFS_END_PTR      16'h00fc
`define OFS_DL_OFFSET    16'h0100
`define OFS_FREE_BYTES   16'h0574
`define OFS_BULK_PORT    16'h0578
`define OFS_IRQ_STATUS   16'h0580
`define OFS_IRQ_ENABLE   16'h0584
`define OFS_IRQ_CLEAR    16'h0588
`define OFS_TRACK_RESULT 16'h7000

// ----------------------------------------------------------------------------
// Ring buffer window and geometry
// ----------------------------------------------------------------------------
`define RING_WIN_TAG     4'h8
`define RING_WORDS       1024
`define PTR_STEP         12'h004
`define DL_STEP          13'h0004

// ----------------------------------------------------------------------------
// Reset and special values
// ----------------------------------------------------------------------------
`define PTR_RESET        12'h000
`define PTR_ERROR        12'hfff
`define FREE_RESET       12'hffc
`define DL_RESET         13'h0000

// ----------------------------------------------------------------------------
// Event bit positions in status, enable and clear
// ----------------------------------------------------------------------------
`define EVT_DRAINED      0
`define EVT_FAULT        1
`define EVT_OVERFLOW     2
`define EVT_WIDTH        3

`endif

/* core/cmd_fifo_pkg.sv */
// Types and shared arithmetic of the command ring
`include "cmd_fifo_defs.svh"
package cmd_fifo_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic [9:0]  addr;
    logic [31:0] data;
  } mem_wr_s;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] tag;
  } track_s;

  typedef struct packed {
    logic        en;
    logic [11:0] value;
  } ptr_load_s;

  // --------------------------------------------------------------------------
  // Fetch states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FETCH_IDLE = 3'b001,
    FETCH_READ = 3'b010,
    FETCH_HOLD = 3'b100
  } fetch_state_e;

  // --------------------------------------------------------------------------
  // Ring pointer step, modulo 4096
  // --------------------------------------------------------------------------
  function automatic logic [11:0] ring_next(input logic [11:0] ptr);
    ring_next = ptr + `PTR_STEP;
  endfunction : ring_next

endpackage : cmd_fifo_pkg

/* core/cmd_ring_mem.sv */
// 4096-byte command ring storage, one write port and one registered read port
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"
module cmd_ring_mem
  import cmd_fifo_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Write side
  input  wire mem_wr_s     wr,
  // Read side, data one cycle after the address
  input  wire logic [9:0]  rd_addr,
  output      logic [31:0] rd_data
);

  logic [31:0] ring_q [0:`RING_WORDS-1];

  always_ff @(posedge clk) begin
    if (wr.en) begin
      ring_q[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= ring_q[rd_addr];
  end

endmodule : cmd_ring_mem

/* core/coprocessor_command_fifo.sv */
// Command ring pointers, bulk port, display-list offset and tracker registers
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"

// Requirements on this block and on the host
// R01: Fetch pointer advances per command taken
// R02: Fault forces fetch pointer to all ones
// R03: Host writes fetch pointer only for recovery
// R04: Reset returns fetch pointer to zero
// R05: Host writes end pointer, 0 to 4095
// R06: End pointer values are word aligned; the block stores the written value without clearing the low bits
// R07: Ring is 4096 bytes, pointers are bytes
// R08: Host loads commands before moving end
// R09: Generated commands land at display-list offset
// R10: Host may set display-list start offset
// R11: Free byte count, resets to 0xffc
// R12: Host reads free count before writing
// R13: Bulk port words append to the ring
// R14: Tracker reads tag low, value high
// R15: Equal pointers mean empty; both wrap
module coprocessor_command_fifo
  import cmd_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Register port
  input  wire logic [15:0] ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output      logic [31:0] RDATA,
  // Command stream to the engine
  output      logic        CMD_VALID,
  output      logic [31:0] CMD_DATA,
  input  wire logic        CMD_READY,
  input  wire logic        CMD_FAULT,
  // Generated display-list commands
  input  wire logic        DL_GEN,
  input  wire logic [31:0] DL_GEN_DATA,
  output      logic        DL_WE,
  output      logic [12:0] DL_ADDR,
  output      logic [31:0] DL_WDATA,
  // Tracker update
  input  wire logic        TRACK_WE,
  input  wire logic [15:0] TRACK_TAG,
  input  wire logic [15:0] TRACK_VALUE,
  // Interrupt
  output      logic        IRQ
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [11:0]           end_q;
  logic [11:0]           fetch_ptr;
  logic [11:0]           free_now;
  logic [11:0]           free_q;
  logic [12:0]           dl_off_q;
  track_s                track_q;
  logic [`EVT_WIDTH-1:0] status_q;
  logic [`EVT_WIDTH-1:0] enable_q;
  logic [`EVT_WIDTH-1:0] event_set;
  logic [`EVT_WIDTH-1:0] event_clr;
  logic                  drained;
  logic                  bulk_hit;
  logic                  bulk_ok;
  logic                  win_hit;
  logic [9:0]            rd_addr;
  logic [31:0]           rd_data;
  logic [31:0]           cmd_data;
  logic                  cmd_valid;
  mem_wr_s               mem_wr;
  ptr_load_s             fetch_load;
  logic [31:0]           rdata_d;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign win_hit  = WR && (ADDR[15:12] == `RING_WIN_TAG);
  assign bulk_hit = WR && hit(ADDR, `OFS_BULK_PORT);

  // --------------------------------------------------------------------------
  // Free space
  // --------------------------------------------------------------------------
  // One word stays unused so that a full ring never looks empty
  assign free_now = (fetch_ptr == `PTR_ERROR) ? 12'h000
                    : fetch_ptr - end_q - `PTR_STEP;     // [R11] [R15]
  assign bulk_ok  = bulk_hit && (free_now >= `PTR_STEP); // [R13]

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      free_q <= `FREE_RESET;                             // [R11]
    end else begin
      free_q <= free_now;                                // [R11]
    end
  end

  // --------------------------------------------------------------------------
  // Ring writes: direct window or bulk port at the end pointer
  // --------------------------------------------------------------------------
  always_comb begin
    mem_wr.en   = win_hit || bulk_ok;
    mem_wr.addr = bulk_ok ? end_q[11:2] : ADDR[11:2];    // [R13] [R07]
    mem_wr.data = WDATA;
  end

  // --------------------------------------------------------------------------
  // End pointer
  // --------------------------------------------------------------------------
  // Stored as written; unaligned values from software are its own fault
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      end_q <= `PTR_RESET;
    end else if (WR && hit(ADDR, `OFS_END_PTR)) begin
      end_q <= WDATA[11:0];                              // [R05] [R06] [R08]
    end else if (bulk_ok) begin
      end_q <= ring_next(end_q);                         // [R13] [R15]
    end
  end

  // --------------------------------------------------------------------------
  // Fetch engine and storage
  // --------------------------------------------------------------------------
  always_comb begin
    fetch_load.en    = WR && hit(ADDR, `OFS_FETCH_PTR);  // [R03]
    fetch_load.value = WDATA[11:0];
  end

  cmd_ring_mem u_ring (
    .clk     (CLK),
    .wr      (mem_wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  cmd_fetch u_fetch (
    .clk         (CLK),
    .rstn        (RSTN),
    .end_ptr     (end_q),
    .load        (fetch_load),
    .fault       (CMD_FAULT),
    .ptr_q       (fetch_ptr),
    .drained_q   (drained),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data),
    .cmd_valid_q (cmd_valid),
    .cmd_data_q  (cmd_data),
    .cmd_ready   (CMD_READY)
  );

  assign CMD_VALID = cmd_valid;
  assign CMD_DATA  = cmd_data;

  // --------------------------------------------------------------------------
  // Display-list write offset
  // --------------------------------------------------------------------------
  // A host write in the same cycle as a generated command wins the offset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      dl_off_q <= `DL_RESET;
    end else if (WR && hit(ADDR, `OFS_DL_OFFSET)) begin
      dl_off_q <= WDATA[12:0];                           // [R10]
    end else if (DL_GEN) begin
      dl_off_q <= dl_off_q + `DL_STEP;                   // [R09]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      DL_WE    <= 1'b0;
      DL_ADDR  <= `DL_RESET;
      DL_WDATA <= 32'h0000_0000;
    end else begin
      DL_WE    <= DL_GEN;
      DL_ADDR  <= dl_off_q;                              // [R09]
      DL_WDATA <= DL_GEN_DATA;
    end
  end

  // --------------------------------------------------------------------------
  // Tracker result
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      track_q <= '0;
    end else if (TRACK_WE) begin
      track_q.tag   <= TRACK_TAG;                        // [R14]
      track_q.value <= TRACK_VALUE;                      // [R14]
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, enable and clear
  // --------------------------------------------------------------------------
  always_comb begin
    event_set                = '0;
    event_set[`EVT_DRAINED]  = drained;
    event_set[`EVT_FAULT]    = CMD_FAULT;
    event_set[`EVT_OVERFLOW] = bulk_hit && !bulk_ok;
    event_clr = (WR && hit(ADDR, `OFS_IRQ_CLEAR)) ? WDATA[`EVT_WIDTH-1:0] : '0;
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~event_clr) | event_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      enable_q <= '0;
    end else if (WR && hit(ADDR, `OFS_IRQ_ENABLE)) begin
      enable_q <= WDATA[`EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((status_q & ~event_clr) | event_set) & enable_q);
    end
  end

  // --------------------------------------------------------------------------
  // Read data, valid in the cycle after the strobe
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ADDR)
      `OFS_FETCH_PTR:    rdata_d = {20'h00000, fetch_ptr};   // [R01]
      `OFS_END_PTR:      rdata_d = {20'h00000, end_q};
      `OFS_DL_OFFSET:    rdata_d = {19'h00000, dl_off_q};
      `OFS_FREE_BYTES:   rdata_d = {20'h00000, free_q};      // [R11]
      `OFS_IRQ_STATUS:   rdata_d = {29'h0000000, status_q};
      `OFS_IRQ_ENABLE:   rdata_d = {29'h0000000, enable_q};
      `OFS_TRACK_RESULT: rdata_d = track_q;                  // [R14]
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rdata_d;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule : coprocessor_command_fifo

/* tb/cmd_fifo_monitor.sv */
// Port checker of the command ring block
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"
module cmd_fifo_monitor (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Command stream
  input wire logic        CMD_VALID,
  input wire logic [31:0] CMD_DATA,
  input wire logic        CMD_READY,
  input wire logic        CMD_FAULT,
  // Display list and tracker
  input wire logic        DL_GEN,
  input wire logic [31:0] DL_GEN_DATA,
  input wire logic        DL_WE,
  input wire logic [12:0] DL_ADDR,
  input wire logic [31:0] DL_WDATA,
  input wire logic        TRACK_WE,
  input wire logic [15:0] TRACK_TAG,
  input wire logic [15:0] TRACK_VALUE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ----
  // Sequences
  // ----
  sequence s_take; CMD_VALID && CMD_READY; endsequence
  sequence s_refill; !CMD_VALID [*2]; endsequence
  sequence s_track_rd; TRACK_WE ##1 (RD && ADDR == `OFS_TRACK_RESULT && !TRACK_WE); endsequence
  // ----
  // Properties
  // ----
  property p_take; s_take |=> s_refill; endproperty
  a_take: assert property (p_take) else $error("refetch too early");
  property p_hold; CMD_VALID && !CMD_READY && !CMD_FAULT && !WR |=> CMD_VALID && $stable(CMD_DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("held command lost");
  property p_fault; CMD_FAULT |=> !CMD_VALID [*4]; endproperty
  a_fault: assert property (p_fault) else $error("fetch after fault");
  property p_dl_we; DL_GEN |=> DL_WE && DL_WDATA == $past(DL_GEN_DATA); endproperty
  a_dl_we: assert property (p_dl_we) else $error("generated word not written");
  property p_dl_step; DL_WE && DL_GEN && !$past(WR) |=> DL_ADDR == $past(DL_ADDR) + 13'h4;
  endproperty
  a_dl_step: assert property (p_dl_step) else $error("offset step wrong");
  property p_track; s_track_rd |=> RDATA == {$past(TRACK_VALUE, 2), $past(TRACK_TAG, 2)};
  endproperty
  a_track: assert property (p_track) else $error("tracker layout wrong");
  property p_fetch_w; RD && ADDR == `OFS_FETCH_PTR |=> RDATA[31:12] == 20'h0; endproperty
  a_fetch_w: assert property (p_fetch_w) else $error("fetch pointer too wide");
  property p_free_w; RD && ADDR == `OFS_FREE_BYTES |=> RDATA[31:12] == 20'h0; endproperty
  a_free_w: assert property (p_free_w) else $error("free count too wide");
  property p_dl_w; RD && ADDR == `OFS_DL_OFFSET |=> RDATA[31:13] == 19'h0; endproperty
  a_dl_w: assert property (p_dl_w) else $error("offset too wide");
endmodule : cmd_fifo_monitor

bind coprocessor_command_fifo cmd_fifo_monitor i_cmd_fifo_monitor (
  .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA), .CMD_READY(CMD_READY), .CMD_FAULT(CMD_FAULT),
  .DL_GEN(DL_GEN), .DL_GEN_DATA(DL_GEN_DATA), .DL_WE(DL_WE), .DL_ADDR(DL_ADDR),
  .DL_WDATA(DL_WDATA), .TRACK_WE(TRACK_WE), .TRACK_TAG(TRACK_TAG), .TRACK_VALUE(TRACK_VALUE));

/* tb/host_model.sv */
// Host model that masters the register port
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"
module host_model (
  // Clock
  input  wire logic        CLK,
  // Register port
  output      logic [15:0] ADDR,
  output      logic [31:0] WDATA,
  output      logic        WR,
  output      logic        RD,
  input  wire logic [31:0] RDATA
);
  initial begin
    ADDR = 16'h0;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    // Released bus must not keep the old word
    WDATA <= ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    d = RDATA;
  endtask : rd
  task automatic bulk(input logic [31:0] d, output logic [31:0] f);
    rd(`OFS_FREE_BYTES, f);
    if (f >= 32'h4) wr(`OFS_BULK_PORT, d);
  endtask : bulk
endmodule : host_model

/* tb/tb_top.sv */
// Self-checking bench of the command ring block
`timescale 1ns/100ps
`include "cmd_fifo_defs.svh"
module tb_top;
  logic CLK, RSTN, WR, RD, CMD_VALID, CMD_READY, CMD_FAULT, DL_GEN, DL_WE, TRACK_WE, IRQ;
  logic [15:0] ADDR, TRACK_TAG, TRACK_VALUE;
  logic [31:0] WDATA, RDATA, CMD_DATA, DL_GEN_DATA, DL_WDATA, v, f;
  logic [12:0] DL_ADDR, dl_exp;
  logic [11:0] end_p;
  logic [31:0] cmd_q[$], dl_q[$];
  logic [15:0] ofs[7] = '{`OFS_FETCH_PTR, `OFS_END_PTR, `OFS_DL_OFFSET, `OFS_FREE_BYTES,
                          `OFS_TRACK_RESULT, `OFS_IRQ_STATUS, 16'h0004};
  logic [31:0] rst[7] = '{32'h0, 32'h0, 32'h0, 32'hffc, 32'h0, 32'h0, 32'h0};
  int bad_count, comparisons;
  bit drain;
  coprocessor_command_fifo i_coprocessor_command_fifo (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA),
    .CMD_READY(CMD_READY), .CMD_FAULT(CMD_FAULT), .DL_GEN(DL_GEN), .DL_GEN_DATA(DL_GEN_DATA),
    .DL_WE(DL_WE), .DL_ADDR(DL_ADDR), .DL_WDATA(DL_WDATA), .TRACK_WE(TRACK_WE),
    .TRACK_TAG(TRACK_TAG), .TRACK_VALUE(TRACK_VALUE), .IRQ(IRQ));
  host_model i_host_model (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] free_exp(input logic [11:0] f, input logic [11:0] e);
    free_exp = (f == 12'hfff) ? 32'h0 : {20'h0, 12'(f - e - 12'h4)};
  endfunction : free_exp
  task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word
  task automatic cmp_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_bit
  task automatic chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_host_model.rd(a, d);
    cmp_word("register", e, d);
  endtask : chk
  task automatic irq_is(input logic e);
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    cmp_bit("irq", e, IRQ);
  endtask : irq_is
  task automatic drain_all;
    drain = 1'b1;
    // Bounded wait so a stuck stream shows as leftover words
    for (int i = 0; i < 20000 && cmd_q.size() != 0; i++) @(posedge CLK);
    drain = 1'b0;
    repeat (4) @(posedge CLK);
    cmp_word("left", 32'h0, 32'(cmd_q.size()));
  endtask : drain_all
  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ----
  // Engine side and capture
  // ----
  always @(posedge CLK) begin
    CMD_READY <= drain && ($urandom_range(1) == 1);
    if (CMD_VALID === 1'b1 && CMD_READY === 1'b1 && cmd_q.size() != 0)
      cmp_word("cmd", cmd_q.pop_front(), CMD_DATA);
    if (DL_WE === 1'b1 && dl_q.size() != 0) begin
      cmp_word("dl_addr", {19'h0, dl_exp}, {19'h0, DL_ADDR});
      cmp_word("dl_data", dl_q.pop_front(), DL_WDATA);
      dl_exp <= dl_exp + 13'h4;
    end
  end
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    repeat (40000) @(posedge CLK);
    bad_count++;
    final_report;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    {RSTN, CMD_READY, CMD_FAULT, DL_GEN, TRACK_WE, drain} = '0;
    {DL_GEN_DATA, TRACK_TAG, TRACK_VALUE} = '0;
    dl_exp = 13'h1ffc;
    v = $urandom(32'h7411);
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    foreach (ofs[i]) chk(ofs[i], rst[i]);
    i_host_model.wr(`OFS_FREE_BYTES, $urandom);
    chk(`OFS_FREE_BYTES, 32'hffc);
    // Fill until the count reaches zero, then one word too many
    end_p = 12'h0;
    repeat (1023) begin
      v = $urandom;
      i_host_model.bulk(v, f);
      cmp_word("free", free_exp(12'h0, end_p), f);
      cmd_q.push_back(v);
      end_p += 12'h4;
    end
    chk(`OFS_FREE_BYTES, free_exp(12'h0, end_p));
    i_host_model.wr(`OFS_BULK_PORT, $urandom);
    chk(`OFS_END_PTR, 32'hffc);
    drain_all;
    chk(`OFS_FETCH_PTR, 32'hffc);
    chk(`OFS_IRQ_STATUS, 32'h5);
    // Interrupt raised, masked and cleared
    i_host_model.wr(`OFS_IRQ_ENABLE, 32'h1);
    irq_is(1'b1);
    i_host_model.wr(`OFS_IRQ_ENABLE, 32'h0);
    irq_is(1'b0);
    i_host_model.wr(`OFS_IRQ_CLEAR, 32'h5);
    i_host_model.wr(`OFS_IRQ_ENABLE, 32'h7);
    chk(`OFS_IRQ_STATUS, 32'h0);
    irq_is(1'b0);
    // Fault, recovery, then a load that wraps the ring
    @(posedge CLK) CMD_FAULT <= 1'b1;
    @(posedge CLK) CMD_FAULT <= 1'b0;
    chk(`OFS_FETCH_PTR, 32'hfff);
    chk(`OFS_FREE_BYTES, 32'h0);
    chk(`OFS_IRQ_STATUS, 32'h2);
    irq_is(1'b1);
    i_host_model.wr(`OFS_END_PTR, 32'hff0);
    i_host_model.wr(`OFS_FETCH_PTR, 32'hff0);
    chk(`OFS_FREE_BYTES, free_exp(12'hff0, 12'hff0));
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      i_host_model.wr({4'h8, 12'(12'hff0 + 4 * i)}, v);
      cmd_q.push_back(v);
    end
    i_host_model.wr(`OFS_END_PTR, 32'h008);
    drain_all;
    chk(`OFS_FETCH_PTR, 32'h008);
    // Generated words across the top of the display-list range
    i_host_model.wr(`OFS_DL_OFFSET, 32'h1ffc);
    repeat (3) begin
      v = $urandom;
      @(posedge CLK);
      DL_GEN <= 1'b1;
      DL_GEN_DATA <= v;
      dl_q.push_back(v);
    end
    @(posedge CLK) DL_GEN <= 1'b0;
    repeat (2) @(posedge CLK);
    cmp_word("dl_left", 32'h0, 32'(dl_q.size()));
    chk(`OFS_DL_OFFSET, 32'h0008);
    // Tracker load and read
    @(posedge CLK);
    v = $urandom;
    TRACK_WE <= 1'b1;
    {TRACK_VALUE, TRACK_TAG} <= v;
    fork
      @(posedge CLK) TRACK_WE <= 1'b0;
      chk(`OFS_TRACK_RESULT, v);
    join
    final_report;
  end
endmodule : tb_top
